// *** rtl/hrcb_restraint.sv ***
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module hrcb_restraint
#(
  parameter int CLK_PERIOD_NS = 50,
  parameter int W = 16,
  parameter bit THREE_WINDING = 1'b1,
  parameter int PICK50_US = 25000,
  parameter int PICK60_US = 20830,
  parameter int DROP50_US = 15000,
  parameter int DROP60_US = 12500,
  parameter logic [15:0] IREF_DEFAULT = 16'h1000,
  parameter logic [15:0] MIN_DIFF_DEFAULT = 16'h0100
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0][W-1:0] diffRe,
  input wire logic [2:0][W-1:0] diffIm,
  input wire logic [2:0][W-1:0] primRe,
  input wire logic [2:0][W-1:0] primIm,
  input wire logic [2:0][W-1:0] secRe,
  input wire logic [2:0][W-1:0] secIm,
  input wire logic [2:0][W-1:0] tertRe,
  input wire logic [2:0][W-1:0] tertIm,
  input wire logic [2:0][W-1:0] h2Mag,
  input wire logic [2:0][W-1:0] h5Mag,
  output logic [2:0][W:0] diffMag,
  output logic [2:0][W:0] primMag,
  output logic [2:0][W:0] secMag,
  output logic [2:0][W:0] tertMag,
  output logic [2:0] secondHarmRestraint,
  output logic [2:0] fifthHarmRestraint,
  output logic second_harm_restraint_any,
  output logic fifth_harm_restraint_any,
  output logic [2:0] elementBlock,
  output logic extFault,
  output logic inrush,
  output logic irq
);
  import hrcb_pkg::*;

  localparam int US_CYCLES_RAW = NS_PER_US / CLK_PERIOD_NS;
  localparam int US_CYCLES = (US_CYCLES_RAW < 1) ? 1 : US_CYCLES_RAW;
  localparam int PW = 2 * W + 16;
  localparam int TW = 16;

  if (W < 8 || W > 24 || PICK50_US >= 65536 || DROP50_US >= 65536 || PICK60_US < 1)
  begin : badParams
    $error("hrcb_restraint: unsupported parameter values");
  end

  function automatic logic [W:0] absVal(input logic [W-1:0] v);
    logic signed [W:0] s;
    s = {v[W-1], v};
    absVal = s[W] ? (W + 1)'(-s) : s;
  endfunction

  // max + 3/8 min: cheap, within about 7 percent of the true magnitude
  function automatic logic [W:0] vecMag(input logic [W-1:0] re, input logic [W-1:0] im);
    logic [W:0] a;
    logic [W:0] b;
    logic [W:0] hi;
    logic [W:0] lo;
    a = absVal(re);
    b = absVal(im);
    hi = (a > b) ? a : b;
    lo = (a > b) ? b : a;
    vecMag = hi + (lo >> 2) + (lo >> 3);
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
    begin
      mergeBytes[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // settings -------------------------------------------------------
  logic crossEn;
  logic sys60;
  logic [RATIO_W-1:0] ratio2;
  logic [RATIO_W-1:0] ratio5;
  logic [15:0] crossLimit;
  logic [15:0] iref;
  logic [15:0] minDiff;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqMask;

  // tick prescalers ------------------------------------------------
  logic [7:0] usDiv;
  logic [9:0] msDiv;
  wire usTick = (usDiv == 8'(US_CYCLES - 1));
  wire msTick = usTick && (msDiv == 10'(US_PER_MS - 1));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      usDiv <= '0;
      msDiv <= '0;
    end
    else
    begin
      usDiv <= usTick ? '0 : usDiv + 8'h01;
      if (usTick)
        msDiv <= (msDiv == 10'(US_PER_MS - 1)) ? '0 : msDiv + 10'h001;
    end
  end

  wire [TW-1:0] pickLim = sys60 ? TW'(PICK60_US) : TW'(PICK50_US);
  wire [TW-1:0] dropLim = sys60 ? TW'(DROP60_US) : TW'(DROP50_US);
  wire [TW-1:0] inrushLim = sys60 ? TW'(INRUSH60_MS) : TW'(INRUSH50_MS);

  // magnitudes and per-phase conditions ----------------------------
  logic [2:0][W:0] dMagC;
  logic [2:0][W:0] pMagC;
  logic [2:0][W:0] sMagC;
  logic [2:0] extPhase;
  logic [2:0] curAbove;
  logic [5:0] harmHigh;
  logic [5:0] harmGate;
  logic [5:0] restr;
  logic inrushAny;
  logic extAny;
  wire [PW-1:0] irefW = PW'(iref);

  for (genvar p = 0; p < 3; p++)
  begin : phase
    logic signed [PW-1:0] dot;
    logic [PW-1:0] magProd;
    logic pValid;
    logic sValid;
    assign dMagC[p] = vecMag(diffRe[p], diffIm[p]);
    assign pMagC[p] = vecMag(primRe[p], primIm[p]);
    assign sMagC[p] = vecMag(secRe[p], secIm[p]);
    assign dot = PW'($signed(primRe[p]) * $signed(secRe[p]))
               + PW'($signed(primIm[p]) * $signed(secIm[p]));
    assign magProd = PW'(pMagC[p]) * PW'(sMagC[p]);
    // both sides above 10 percent of reference
    assign pValid = PW'(pMagC[p]) * PW'(PCT_FULL) > irefW * PW'(EXT_VALID_PCT);
    assign sValid = PW'(sMagC[p]) * PW'(PCT_FULL) > irefW * PW'(EXT_VALID_PCT);
    // angle >= 75 deg <=> cos(angle) <= cos 75
    assign extPhase[p] = pValid && sValid
                         && ((dot <= 0) || ((dot <<< COS75_SHIFT)
                             <= $signed(magProd * PW'(COS75_NUM))));
    assign curAbove[p] = (PW'(pMagC[p]) * PW'(PCT_FULL) > irefW * PW'(INRUSH_CUR_PCT))
                      || (PW'(sMagC[p]) * PW'(PCT_FULL) > irefW * PW'(INRUSH_CUR_PCT));

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        diffMag[p] <= '0;
        primMag[p] <= '0;
        secMag[p] <= '0;
        tertMag[p] <= '0;
      end
      else
      begin
        diffMag[p] <= dMagC[p];
        primMag[p] <= pMagC[p];
        secMag[p] <= sMagC[p];
        // tertiary only in the three-winding variant
        tertMag[p] <= THREE_WINDING ? vecMag(tertRe[p], tertIm[p]) : '0;
      end
    end
  end

  // elements 0..2: second harmonic, 3..5: fifth harmonic
  for (genvar g = 0; g < 6; g++)
  begin : element
    localparam int P = g % 3;
    localparam bit FIFTH = (g >= 3);
    logic [TW-1:0] pickCnt;
    logic [TW-1:0] dropCnt;
    wire [W-1:0] hMag = FIFTH ? h5Mag[P] : h2Mag[P];
    wire [RATIO_W-1:0] rat = FIFTH ? ratio5 : ratio2;
    wire pickDone = (pickCnt == pickLim);
    // harmonic * 100 >= ratio * fundamental
    assign harmHigh[g] = (dMagC[P] != '0)
                         && (PW'(hMag) * PW'(PCT_FULL) >= PW'(rat) * PW'(dMagC[P]));
    // fifth gated by minimum diff current; second by inrush or fault
    assign harmGate[g] = FIFTH ? (dMagC[P] >= (W + 1)'(minDiff)) : (inrush || extFault);

    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        pickCnt <= '0;
        dropCnt <= '0;
        restr[g] <= 1'b0;
      end
      else
      begin
        // pickup runs only while the ratio stays high
        if (!harmHigh[g])
          pickCnt <= '0;
        else if (usTick && !pickDone)
          pickCnt <= pickCnt + 1'b1;
        // drop-off extension armed after continuous pickup
        if (harmHigh[g] && pickDone)
          dropCnt <= dropLim;
        else if (usTick && dropCnt != '0)
          dropCnt <= dropCnt - 1'b1;
        // restraint follows high ratio at once
        restr[g] <= harmGate[g] && (harmHigh[g] || dropCnt != '0);
      end
    end
  end

  logic [TW-1:0] inrushCnt;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      inrushCnt <= '0;
      inrush <= 1'b1;
    end
    else if (!(|curAbove))
    begin
      inrushCnt <= '0;
      inrush <= 1'b1;
    end
    else if (|harmHigh[2:0])
      inrushCnt <= '0;
    else if (msTick && inrush)
    begin
      inrushCnt <= inrushCnt + 1'b1;
      if (inrushCnt >= inrushLim - 1'b1)
        inrush <= 1'b0;
    end
  end

  // cross blocking --------------------------------------------------
  logic [15:0] crossCnt;
  logic crossExp;
  wire [2:0] selfBlk = restr[2:0] | restr[5:3];
  wire anyBlk = |selfBlk;
  // all elements blocked while cross blocking runs
  wire crossOn = crossEn && anyBlk && !crossExp;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crossCnt <= '0;
      crossExp <= 1'b0;
    end
    else if (!crossEn || !anyBlk)
    begin
      crossCnt <= '0;
      crossExp <= 1'b0;
    end
    else if (msTick && !crossExp)
    begin
      crossCnt <= crossCnt + 16'h0001;
      if (crossCnt >= crossLimit - 16'h0001)
        crossExp <= 1'b1;
    end
  end

  // summary outputs; self blocking kept after timeout
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      secondHarmRestraint <= '0;
      fifthHarmRestraint <= '0;
      second_harm_restraint_any <= 1'b0;
      fifth_harm_restraint_any <= 1'b0;
      elementBlock <= '0;
      extFault <= 1'b0;
    end
    else
    begin
      secondHarmRestraint <= restr[2:0];
      fifthHarmRestraint <= restr[5:3];
      second_harm_restraint_any <= |restr[2:0];
      fifth_harm_restraint_any <= |restr[5:3];
      elementBlock <= selfBlk | {3{crossOn}};
      extFault <= |extPhase;
    end
  end

  // register bus ----------------------------------------------------
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic awFull;
  logic wFull;
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire doWrite = awFull && wFull && !bvalid;
  wire arTake = arvalid && arready;

  wire wrCtrl = doWrite && awAddrQ[7:2] == ADDR_CTRL[7:2];
  wire wrRatio = doWrite && awAddrQ[7:2] == ADDR_RATIO[7:2];
  wire wrCross = doWrite && awAddrQ[7:2] == ADDR_CROSS_LIMIT[7:2];
  wire wrIref = doWrite && awAddrQ[7:2] == ADDR_IREF[7:2];
  wire wrMinDiff = doWrite && awAddrQ[7:2] == ADDR_MIN_DIFF[7:2];
  wire wrIrqStat = doWrite && awAddrQ[7:2] == ADDR_IRQ_STAT[7:2];
  wire wrIrqMask = doWrite && awAddrQ[7:2] == ADDR_IRQ_MASK[7:2];
  wire wrHit = wrCtrl || wrRatio || wrCross || wrIref || wrMinDiff || wrIrqStat || wrIrqMask
               || (awAddrQ[7:2] == ADDR_STATUS[7:2]);

  wire [31:0] ctrlWord = 32'({sys60, crossEn});
  wire [31:0] ratioWord = 32'({2'b00, ratio5, 2'b00, ratio2});
  wire [31:0] statusWord = 32'({crossExp, inrush, extFault, fifth_harm_restraint_any,
                                second_harm_restraint_any, elementBlock,
                                fifthHarmRestraint, secondHarmRestraint});
  wire [31:0] newCtrl = mergeBytes(ctrlWord, wDataQ, wStrbQ);
  wire [31:0] newRatio = mergeBytes(ratioWord, wDataQ, wStrbQ);
  wire [31:0] newCross = mergeBytes(32'(crossLimit), wDataQ, wStrbQ);
  wire [31:0] newIref = mergeBytes(32'(iref), wDataQ, wStrbQ);
  wire [31:0] newMinDiff = mergeBytes(32'(minDiff), wDataQ, wStrbQ);
  wire [31:0] newMask = mergeBytes(32'(irqMask), wDataQ, wStrbQ);
  wire [31:0] clrWord = mergeBytes(32'h0, wDataQ, wStrbQ);
  wire [RATIO_W-1:0] r2In = newRatio[RATIO_R2_LSB +: RATIO_W];
  wire [RATIO_W-1:0] r5In = newRatio[RATIO_R5_LSB +: RATIO_W];
  wire [15:0] crossIn = newCross[15:0];

  wire [7:0] rA = araddr;
  wire rdHit = rA[7:2] <= ADDR_IRQ_MASK[7:2];
  wire [31:0] rdMux =
    (rA[7:2] == ADDR_CTRL[7:2]) ? ctrlWord :
    (rA[7:2] == ADDR_RATIO[7:2]) ? ratioWord :
    (rA[7:2] == ADDR_CROSS_LIMIT[7:2]) ? 32'(crossLimit) :
    (rA[7:2] == ADDR_IREF[7:2]) ? 32'(iref) :
    (rA[7:2] == ADDR_MIN_DIFF[7:2]) ? 32'(minDiff) :
    (rA[7:2] == ADDR_STATUS[7:2]) ? statusWord :
    (rA[7:2] == ADDR_IRQ_STAT[7:2]) ? 32'(irqStat) :
    (rA[7:2] == ADDR_IRQ_MASK[7:2]) ? 32'(irqMask) : 32'h0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      awFull <= 1'b0;
      wFull <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= '0;
      wStrbQ <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (awTake)
      begin
        awAddrQ <= awaddr;
        awFull <= 1'b1;
        awready <= 1'b0;
      end
      if (wTake)
      begin
        wDataQ <= wdata;
        wStrbQ <= wstrb;
        wFull <= 1'b1;
        wready <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
        awFull <= 1'b0;
        wFull <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arTake)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // out-of-range settings are clamped so timers never see nonsense
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      crossEn <= CROSS_EN_DEFAULT;
      sys60 <= 1'b0;
      ratio2 <= RATIO2_DEFAULT;
      ratio5 <= RATIO5_DEFAULT;
      crossLimit <= CROSS_DEFAULT_MS;
      iref <= IREF_DEFAULT;
      minDiff <= MIN_DIFF_DEFAULT;
      irqMask <= '0;
    end
    else
    begin
      if (wrCtrl)
      begin
        crossEn <= newCtrl[CTRL_CROSS_EN_BIT];
        sys60 <= newCtrl[CTRL_SYS60_BIT];
      end
      if (wrRatio)
      begin
        ratio2 <= (r2In < RATIO_MIN) ? RATIO_MIN : (r2In > RATIO_MAX) ? RATIO_MAX : r2In;
        ratio5 <= (r5In < RATIO_MIN) ? RATIO_MIN : (r5In > RATIO_MAX) ? RATIO_MAX : r5In;
      end
      if (wrCross)
        crossLimit <= (crossIn < CROSS_MIN_MS) ? CROSS_MIN_MS :
                      (crossIn > CROSS_MAX_MS) ? CROSS_MAX_MS : crossIn;
      if (wrIref)
        iref <= newIref[15:0];
      if (wrMinDiff)
        minDiff <= newMinDiff[15:0];
      if (wrIrqMask)
        irqMask <= newMask[IRQ_W-1:0];
    end
  end

  // interrupts: rising edges of the summary flags, set wins over clear
  wire [IRQ_W-1:0] irqEv;
  assign irqEv[IRQ_SECOND] = (|restr[2:0]) && !second_harm_restraint_any;
  assign irqEv[IRQ_FIFTH] = (|restr[5:3]) && !fifth_harm_restraint_any;
  assign irqEv[IRQ_EXTF] = (|extPhase) && !extFault;
  assign irqEv[IRQ_CROSS_EXP] = crossEn && anyBlk && msTick && !crossExp
                                && (crossCnt >= crossLimit - 16'h0001);
  wire [IRQ_W-1:0] irqClr = wrIrqStat ? clrWord[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqStat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irqStat <= (irqStat & ~irqClr) | irqEv;
      irq <= |(((irqStat & ~irqClr) | irqEv) & irqMask);
    end
  end
endmodule

// *** rtl/hrcb_pkg.sv ***
// Behaviour
// - external fault when side angles differ >=75 degrees
// - angle valid only above 10% reference current
// - per-phase harmonic/fundamental ratio against both settings
// - high ratio restrains at once, starts pickup
// - drop-off extension armed after 25/20.83 ms continuous
// - 60 Hz drop-off extension is 12.5 ms
// - second harmonic restraint only under inrush/fault
// - OR of phase second harmonic restraints
// - fifth harmonic gated only by minimum diff current
// - cross off: element blocks only itself
// - cross on: any blocked element blocks all
// - cross blocking released after limit, self-block stays
// - cross limit 100..60000 ms, default 5000
// - cross blocking enabled by default
// - magnitudes of diff, primary, secondary, optional tertiary
// - ratio settings 5..50 percent, defaults 15/25
// - inrush drops after 5/4.167 s with current, no 2nd
package hrcb_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RATIO = 8'h04;
  localparam logic [7:0] ADDR_CROSS_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_IREF = 8'h0c;
  localparam logic [7:0] ADDR_MIN_DIFF = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  localparam int CTRL_CROSS_EN_BIT = 0;
  localparam int CTRL_SYS60_BIT = 1;
  localparam int RATIO_R2_LSB = 0;
  localparam int RATIO_R5_LSB = 8;
  localparam int RATIO_W = 6;
  localparam logic [5:0] RATIO_MIN = 6'h05;
  localparam logic [5:0] RATIO_MAX = 6'h32;
  localparam logic [5:0] RATIO2_DEFAULT = 6'h0f;
  localparam logic [5:0] RATIO5_DEFAULT = 6'h19;
  localparam logic [15:0] CROSS_MIN_MS = 16'h0064;
  localparam logic [15:0] CROSS_MAX_MS = 16'hea60;
  localparam logic [15:0] CROSS_DEFAULT_MS = 16'h1388;
  localparam logic CROSS_EN_DEFAULT = 1'b1;
  localparam int PCT_FULL = 100;
  localparam int EXT_VALID_PCT = 10;
  localparam int INRUSH_CUR_PCT = 2;
  localparam int INRUSH50_MS = 5000;
  localparam int INRUSH60_MS = 4167;
  localparam int US_PER_MS = 1000;
  localparam int NS_PER_US = 1000;
  // cos(75 deg) ~ 66/256
  localparam int COS75_NUM = 66;
  localparam int COS75_SHIFT = 8;
  localparam int IRQ_W = 4;
  localparam int IRQ_SECOND = 0;
  localparam int IRQ_FIFTH = 1;
  localparam int IRQ_EXTF = 2;
  localparam int IRQ_CROSS_EXP = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** testbench/hrcb_restraint_checker.sv ***
`timescale 1ns/1ps
module hrcb_restraint_checker
#(
  parameter int W = 16
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [2:0][W-1:0] diffRe,
  input wire logic [2:0][W-1:0] diffIm,
  input wire logic [2:0][W-1:0] h2Mag,
  input wire logic [2:0][W-1:0] h5Mag,
  input wire logic [2:0][W:0] diffMag,
  input wire logic [2:0] secondHarmRestraint,
  input wire logic [2:0] fifthHarmRestraint,
  input wire logic second_harm_restraint_any,
  input wire logic fifth_harm_restraint_any,
  input wire logic [2:0] elementBlock,
  input wire logic extFault,
  input wire logic inrush
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_mag_follows: assert property (
    diffIm[0] == '0 && !diffRe[0][W-1] |=> diffMag[0] == {1'b0, $past(diffRe[0])})
    else $error("diff magnitude wrong");
  a_second_any: assert property (
    second_harm_restraint_any == (|secondHarmRestraint))
    else $error("second summary not OR of phases");
  a_fifth_any: assert property (
    fifth_harm_restraint_any == (|fifthHarmRestraint))
    else $error("fifth summary not OR of phases");
  a_second_gated: assert property (
    |secondHarmRestraint |-> inrush || extFault || $past(inrush, 2) || $past(extFault, 2))
    else $error("second restraint without inrush or fault");
  a_fifth_cause: assert property (
    $rose(fifthHarmRestraint[1]) |-> $past(h5Mag[1], 2) != '0)
    else $error("fifth restraint without fifth content");
  a_self_block: assert property (
    ((secondHarmRestraint | fifthHarmRestraint) & ~elementBlock) == 3'h0)
    else $error("restrained element not blocked");
  a_second_prompt: assert property (
    (inrush && diffIm[0] == '0 && !diffRe[0][W-1] && diffRe[0] != '0
      && h2Mag[0] > (diffRe[0] >> 1)) [*3] |-> secondHarmRestraint[0])
    else $error("second restraint late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  c_second: cover property ($rose(second_harm_restraint_any));
  c_fifth: cover property ($rose(fifth_harm_restraint_any));
  c_ext: cover property ($rose(extFault));
endmodule

// *** testbench/hrcb_source.sv ***
`timescale 1ns/1ps
module hrcb_source
#(
  parameter int W = 16
)
(
  input wire logic [2:0][W-1:0] fund,
  input wire logic [2:0][7:0] h2Pct,
  input wire logic [2:0][7:0] h5Pct,
  input wire logic [2:0] oppose,
  output logic [2:0][W-1:0] diffRe,
  output logic [2:0][W-1:0] diffIm,
  output logic [2:0][W-1:0] primRe,
  output logic [2:0][W-1:0] primIm,
  output logic [2:0][W-1:0] secRe,
  output logic [2:0][W-1:0] secIm,
  output logic [2:0][W-1:0] tertRe,
  output logic [2:0][W-1:0] tertIm,
  output logic [2:0][W-1:0] h2Mag,
  output logic [2:0][W-1:0] h5Mag
);
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      diffRe[p] = fund[p];
      diffIm[p] = '0;
      primRe[p] = fund[p];
      primIm[p] = '0;
      // a saturated far side shows up turned half a cycle
      secRe[p] = oppose[p] ? -fund[p] : fund[p];
      secIm[p] = '0;
      tertRe[p] = fund[p] >> 1;
      tertIm[p] = fund[p] >> 2;
      h2Mag[p] = W'((32'(fund[p]) * 32'(h2Pct[p])) / 32'd100);
      h5Mag[p] = W'((32'(fund[p]) * 32'(h5Pct[p])) / 32'd100);
    end
  end
endmodule

// *** testbench/tb_harmonic_restraint_cross_block.sv ***
`timescale 1ns/1ps
module tb_harmonic_restraint_cross_block;
  import hrcb_pkg::*;
  localparam int W = 16;
  localparam int PICK = 20;
  localparam int DROP = 10;
  logic clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic second_harm_restraint_any, fifth_harm_restraint_any, extFault, inrush, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [2:0][W-1:0] diffRe, diffIm, primRe, primIm, secRe, secIm, tertRe, tertIm;
  logic [2:0][W-1:0] h2Mag, h5Mag, fund;
  logic [2:0][W:0] diffMag, primMag, secMag, tertMag;
  logic [2:0][7:0] h2Pct, h5Pct;
  logic [2:0] oppose, secondHarmRestraint, fifthHarmRestraint, elementBlock;
  int err_count = 0;
  int samples_checked = 0;
  // us prescale of one cycle keeps pickup and drop-off short
  hrcb_restraint #(.CLK_PERIOD_NS(1000), .PICK50_US(PICK), .PICK60_US(PICK),
    .DROP50_US(DROP), .DROP60_US(DROP)) u_hrcb_restraint (.clk, .nrst, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .diffRe, .diffIm,
    .primRe, .primIm, .secRe, .secIm, .tertRe, .tertIm, .h2Mag, .h5Mag, .diffMag,
    .primMag, .secMag, .tertMag, .secondHarmRestraint, .fifthHarmRestraint,
    .second_harm_restraint_any, .fifth_harm_restraint_any, .elementBlock, .extFault,
    .inrush, .irq);
  hrcb_source #(.W(W)) u_hrcb_source (.fund, .h2Pct, .h5Pct, .oppose, .diffRe, .diffIm,
    .primRe, .primIm, .secRe, .secIm, .tertRe, .tertIm, .h2Mag, .h5Mag);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end while (!hb);
    chk("bresp", 32'(er), 32'(r));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end while (!hr);
    chk("rdata", ed, d);
    chk("rresp", 32'(er), 32'(r));
  endtask
  task automatic drive(input int p, input logic [15:0] f, input logic [7:0] a2,
    input logic [7:0] a5, input logic o);
    @(posedge clk);
    fund[p] <= f;
    h2Pct[p] <= a2;
    h5Pct[p] <= a5;
    oppose[p] <= o;
  endtask
  task automatic after(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_regs();
    chk("inrush", 32'h1, 32'(inrush));
    axi_rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h3, RESP_OKAY);
    axi_rd(ADDR_CTRL, 32'h3, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    axi_rd(ADDR_RATIO, 32'h190f, RESP_OKAY);
    axi_rd(ADDR_CROSS_LIMIT, 32'h1388, RESP_OKAY);
    axi_wr(ADDR_RATIO, 32'h3f01, RESP_OKAY);
    axi_rd(ADDR_RATIO, 32'h3205, RESP_OKAY);
    axi_wr(ADDR_RATIO, 32'h190f, RESP_OKAY);
    axi_wr(ADDR_CROSS_LIMIT, 32'h10, RESP_OKAY);
    axi_rd(ADDR_CROSS_LIMIT, 32'h64, RESP_OKAY);
    axi_wr(ADDR_CROSS_LIMIT, 32'hffff, RESP_OKAY);
    axi_rd(ADDR_CROSS_LIMIT, 32'hea60, RESP_OKAY);
    axi_wr(ADDR_CROSS_LIMIT, 32'h1388, RESP_OKAY);
    axi_wr(8'h20, 32'h1, RESP_SLVERR);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_mag();
    logic [15:0] f;
    for (int p = 0; p < 3; p++)
      drive(p, 16'h0400 + 16'(p) * 16'h0200, 8'h00, 8'h00, 1'b0);
    after(2);
    for (int p = 0; p < 3; p++)
    begin
      f = fund[p];
      chk("diffMag", 32'(f), 32'(diffMag[p]));
      chk("primMag", 32'(f), 32'(primMag[p]));
      chk("secMag", 32'(f), 32'(secMag[p]));
      chk("tertMag", 32'(f / 2 + f / 16 + f / 32), 32'(tertMag[p]));
    end
  endtask
  task automatic t_ext();
    drive(0, 16'h0800, 8'h00, 8'h00, 1'b1);
    after(3);
    chk("extFault", 32'h1, 32'(extFault));
    drive(0, 16'h0100, 8'h00, 8'h00, 1'b1);
    after(3);
    chk("extFault", 32'h0, 32'(extFault));
    drive(0, 16'h0800, 8'h00, 8'h00, 1'b0);
    after(3);
    chk("extFault", 32'h0, 32'(extFault));
  endtask
  task automatic t_second();
    drive(0, 16'h0800, 8'd60, 8'h00, 1'b0);
    after(2);
    chk("second", 32'h1, 32'(secondHarmRestraint));
    chk("secondAny", 32'h1, 32'(second_harm_restraint_any));
    chk("elementBlock", 32'h7, 32'(elementBlock));
    axi_rd(ADDR_STATUS, 32'h13c1, RESP_OKAY);
    after(4);
    drive(0, 16'h0800, 8'd0, 8'h00, 1'b0);
    after(3);
    chk("second", 32'h0, 32'(secondHarmRestraint));
    drive(0, 16'h0800, 8'd10, 8'h00, 1'b0);
    after(4);
    chk("second", 32'h0, 32'(secondHarmRestraint));
    drive(0, 16'h0800, 8'd60, 8'h00, 1'b0);
    after(PICK + 10);
    drive(0, 16'h0800, 8'd0, 8'h00, 1'b0);
    after(DROP / 2 + 2);
    chk("secondHeld", 32'h1, 32'(secondHarmRestraint));
    after(DROP + 4);
    chk("second", 32'h0, 32'(secondHarmRestraint));
  endtask
  task automatic t_fifth();
    axi_wr(ADDR_IRQ_MASK, 32'h1 << IRQ_FIFTH, RESP_OKAY);
    drive(1, 16'h0800, 8'd0, 8'd40, 1'b0);
    after(2);
    chk("fifth", 32'h2, 32'(fifthHarmRestraint));
    chk("fifthAny", 32'h1, 32'(fifth_harm_restraint_any));
    after(2);
    chk("irq", 32'h1, 32'(irq));
    drive(1, 16'h0800, 8'd0, 8'd0, 1'b0);
    after(3);
    chk("irqSticky", 32'h1, 32'(irq));
    axi_wr(ADDR_IRQ_STAT, 32'h1 << IRQ_FIFTH, RESP_OKAY);
    after(1);
    chk("irq", 32'h0, 32'(irq));
    drive(1, 16'h0080, 8'd0, 8'd40, 1'b0);
    after(4);
    chk("fifthSmall", 32'h0, 32'(fifthHarmRestraint));
    drive(1, 16'h0800, 8'd0, 8'd0, 1'b0);
  endtask
  task automatic t_cross_off();
    axi_wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    drive(2, 16'h0800, 8'd60, 8'h00, 1'b0);
    after(2);
    chk("elementBlock", 32'h4, 32'(elementBlock));
    drive(2, 16'h0800, 8'd0, 8'h00, 1'b0);
    axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial
  begin
    nrst = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    fund = {3{16'h0800}};
    h2Pct = '0;
    h5Pct = '0;
    oppose = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_mag();
    t_ext();
    t_second();
    t_fifth();
    t_cross_off();
    test_done();
  end
endmodule
bind hrcb_restraint hrcb_restraint_checker #(.W(W)) u_hrcb_restraint_checker (.clk, .nrst,
  .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .diffRe, .diffIm, .h2Mag, .h5Mag,
  .diffMag, .secondHarmRestraint, .fifthHarmRestraint, .second_harm_restraint_any,
  .fifth_harm_restraint_any, .elementBlock, .extFault, .inrush);
